//--- nvm_params.svh
// register offsets, field positions, key values and reset values of the self-access controller
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
`define NVM_OFS_CONTROL 9'h18C
`define NVM_OFS_UNLOCK 9'h18D
`define NVM_OFS_DATA_LOW 9'h10C
`define NVM_OFS_ADDR_LOW 9'h10D
`define NVM_OFS_DATA_HIGH 9'h10E
`define NVM_OFS_ADDR_HIGH 9'h10F
`define NVM_BIT_SPACE 7
`define NVM_BIT_ABORT 3
`define NVM_BIT_PERMIT 2
`define NVM_BIT_WRITE 1
`define NVM_BIT_READ 0
`define NVM_UNLOCK_FIRST 8'h55
`define NVM_UNLOCK_SECOND 8'hAA
`define NVM_DATA_HIGH_W 6
`define NVM_FLASH_ADDR_HIGH_W 5
`define NVM_BYTE_ZERO 8'h00
`define NVM_TIMER_ZERO 16'h0000
`define NVM_TIMER_ONE 16'h0001
`endif

//--- nvm_pkg.sv
// shared types of the nonvolatile self-access controller
package nvm_pkg;
	typedef struct packed {
		logic [8:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_type;

	typedef struct packed {
		logic space;
		logic abort;
		logic permit;
		logic wr;
		logic rd;
	} ctrl_type;

	typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_RD_LOAD, ST_ERASE, ST_PROGRAM} nvm_state_type;

	typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_ARMED} unlock_type;
endpackage

//--- nvm_store.sv
// flip-flop storage for the data byte array and the program word array
`timescale 1ns/1ps
module nvm_store #(
	parameter int EE_DEPTH = 64,
	parameter int EE_AW    = 6,
	parameter int FL_DEPTH = 2048,
	parameter int FL_AW    = 11,
	parameter int FL_W     = 14
) (
	// clock
	input  wire logic              i_clock,
	input  wire logic              i_clock_en,
	// access
	input  wire logic              i_space,
	input  wire logic [EE_AW-1:0]  i_ee_index,
	input  wire logic [FL_AW-1:0]  i_fl_index,
	input  wire logic              i_erase,
	input  wire logic              i_program,
	input  wire logic [FL_W-1:0]   i_wdata,
	// read data
	output logic      [7:0]        o_ee_rdata,
	output logic      [FL_W-1:0]   o_fl_rdata
);
	logic [7:0]      ee_mem [EE_DEPTH];
	logic [FL_W-1:0] fl_mem [FL_DEPTH];

	assign o_ee_rdata = ee_mem[i_ee_index];
	assign o_fl_rdata = fl_mem[i_fl_index];

	// only single-location erase exists: no path can clear a whole array
	always_ff @(posedge i_clock) begin
		if (i_clock_en && !i_space) begin
			if (i_erase)
				ee_mem[i_ee_index] <= '1;
			else if (i_program)
				ee_mem[i_ee_index] <= ee_mem[i_ee_index] & i_wdata[7:0];
		end
	end

	// programming can only clear bits, so a write without its erase would corrupt the cell
	always_ff @(posedge i_clock) begin
		if (i_clock_en && i_space) begin
			if (i_erase)
				fl_mem[i_fl_index] <= '1;
			else if (i_program)
				fl_mem[i_fl_index] <= fl_mem[i_fl_index] & i_wdata;
		end
	end
endmodule // nvm_store

//--- nvm_self_access_ctrl.sv
// register-driven read and write controller for data bytes and program words
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_self_access_ctrl #(
	parameter int ERASE_CYCLES   = 40,
	parameter int PROGRAM_CYCLES = 40,
	parameter int EE_DEPTH       = 64,
	parameter int EE_AW          = 6,
	parameter int FL_DEPTH       = 2048,
	parameter int FL_AW          = 11,
	parameter int FL_W           = 14
) (
	// clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	input  wire logic                 i_clock_en,
	// special function register port of the core
	input  nvm_pkg::sfr_req_type      i_sfr,
	output logic      [7:0]           o_sfr_rdata,
	// soft resets
	input  wire logic                 i_external_reset_pin,
	input  wire logic                 i_watchdog_timeout,
	// core coordination
	output logic                      o_cpu_stall,
	output logic                      o_irq_hold,
	output logic                      o_write_done
);
	import nvm_pkg::*;

	logic [7:0]                  addr_low;
	logic [7:0]                  addr_high;
	logic [7:0]                  data_low;
	logic [`NVM_DATA_HIGH_W-1:0] data_high;
	ctrl_type                    ctrl;
	nvm_state_type               state;
	unlock_type                  unlock;
	logic [15:0]                 timer;
	logic                        ext_sync1;
	logic                        ext_sync2;
	logic                        ext_sync3;
	logic                        ext_level;

	function automatic logic hit(input sfr_req_type req, input logic [8:0] ofs);
		hit = req.wr && (req.addr == ofs);
	endfunction

	function automatic logic rd_hit(input sfr_req_type req, input logic [8:0] ofs);
		rd_hit = req.rd && (req.addr == ofs);
	endfunction

	logic [7:0]      ee_rdata;
	logic [FL_W-1:0] fl_rdata;
	logic [12:0]     word_addr;
	logic            busy;
	logic            writing;
	logic            soft_reset;
	logic            wr_ctrl;
	logic            wr_unlock;
	logic            start_write;
	logic            start_read;
	logic            timer_end;
	logic            erase_pulse;
	logic            program_pulse;
	logic            load_data;
	logic [7:0]      ctrl_byte;
	logic [7:0]      read_mux;
	logic [15:0]     erase_len;
	logic [15:0]     program_len;

	assign erase_len   = 16'(ERASE_CYCLES);
	assign program_len = 16'(PROGRAM_CYCLES);

	assign word_addr  = {addr_high[`NVM_FLASH_ADDR_HIGH_W-1:0], addr_low};
	assign busy       = (state != ST_IDLE);
	assign writing    = (state == ST_ERASE) || (state == ST_PROGRAM);
	assign soft_reset = ext_level || i_watchdog_timeout;
	assign wr_ctrl    = hit(i_sfr, `NVM_OFS_CONTROL) && !soft_reset;
	assign wr_unlock  = hit(i_sfr, `NVM_OFS_UNLOCK) && !soft_reset;
	// permit must already stand and the key must come just before
	assign start_write = wr_ctrl && i_sfr.wdata[`NVM_BIT_WRITE] && !busy && ctrl.permit
		&& (unlock == UNLOCK_ARMED);
	assign start_read  = wr_ctrl && i_sfr.wdata[`NVM_BIT_READ] && !busy && !start_write;
	assign timer_end     = (timer == `NVM_TIMER_ONE);
	assign erase_pulse   = start_write;
	assign program_pulse = (state == ST_ERASE) && timer_end;
	assign load_data     = (state == ST_RD_LOAD);

	assign ctrl_byte = {ctrl.space, 3'b000, ctrl.abort, ctrl.permit, ctrl.wr, ctrl.rd};
	// unlock port has no storage and reads zero
	assign read_mux =
		rd_hit(i_sfr, `NVM_OFS_CONTROL)   ? ctrl_byte :
		rd_hit(i_sfr, `NVM_OFS_DATA_LOW)  ? data_low :
		rd_hit(i_sfr, `NVM_OFS_DATA_HIGH) ? {2'b00, data_high} :
		rd_hit(i_sfr, `NVM_OFS_ADDR_LOW)  ? addr_low :
		rd_hit(i_sfr, `NVM_OFS_ADDR_HIGH) ? addr_high : `NVM_BYTE_ZERO;

	// a program write stops the core but not the clock, so peripherals keep running
	assign o_cpu_stall = writing && ctrl.space;
	assign o_irq_hold  = writing && ctrl.space;

	nvm_store #(
		.EE_DEPTH (EE_DEPTH),
		.EE_AW    (EE_AW),
		.FL_DEPTH (FL_DEPTH),
		.FL_AW    (FL_AW),
		.FL_W     (FL_W)
	) u_store (
		.i_clock    (i_clock),
		.i_clock_en (i_clock_en),
		.i_space    (ctrl.space),
		.i_ee_index (addr_low[EE_AW-1:0]),
		.i_fl_index (word_addr[FL_AW-1:0]),
		.i_erase    (erase_pulse),
		.i_program  (program_pulse),
		.i_wdata    ({data_high, data_low}),
		.o_ee_rdata (ee_rdata),
		.o_fl_rdata (fl_rdata)
	);

	// pin synchroniser; the level moves only when the last two stages agree
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ext_sync1 <= 1'b0;
			ext_sync2 <= 1'b0;
			ext_sync3 <= 1'b0;
			ext_level <= 1'b0;
		end else if (i_clock_en) begin
			ext_sync1 <= i_external_reset_pin;
			ext_sync2 <= ext_sync1;
			ext_sync3 <= ext_sync2;
			if (ext_sync2 == ext_sync3)
				ext_level <= ext_sync3;
		end
	end

	// key sequence tracker; any other register write breaks it
	always_ff @(posedge i_clock) begin
		if (i_rst || (i_clock_en && soft_reset))
			unlock <= UNLOCK_IDLE;
		else if (i_clock_en && i_sfr.wr) begin
			if (wr_unlock && i_sfr.wdata == `NVM_UNLOCK_FIRST)
				unlock <= UNLOCK_HALF;
			else if (wr_unlock && i_sfr.wdata == `NVM_UNLOCK_SECOND && unlock == UNLOCK_HALF)
				unlock <= UNLOCK_ARMED;
			else
				unlock <= UNLOCK_IDLE;
		end
	end

	// address registers; soft resets leave them alone
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			addr_low  <= `NVM_BYTE_ZERO;
			addr_high <= `NVM_BYTE_ZERO;
		end else if (i_clock_en && !soft_reset) begin
			if (hit(i_sfr, `NVM_OFS_ADDR_LOW))
				addr_low <= i_sfr.wdata;
			if (hit(i_sfr, `NVM_OFS_ADDR_HIGH))
				addr_high <= i_sfr.wdata;
		end
	end

	// data registers; a finished read wins over a software write in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			data_low  <= `NVM_BYTE_ZERO;
			data_high <= '0;
		end else if (i_clock_en && !soft_reset) begin
			if (load_data && !ctrl.space)
				data_low <= ee_rdata;
			else if (load_data)
				{data_high, data_low} <= fl_rdata;
			else begin
				if (hit(i_sfr, `NVM_OFS_DATA_LOW))
					data_low <= i_sfr.wdata;
				if (hit(i_sfr, `NVM_OFS_DATA_HIGH))
					data_high <= i_sfr.wdata[`NVM_DATA_HIGH_W-1:0];
			end
		end
	end

	// control register
	always_ff @(posedge i_clock) begin
		if (i_rst)
			ctrl <= '0;
		else if (i_clock_en) begin
			if (soft_reset) begin
				ctrl.abort  <= ctrl.abort || writing;
				ctrl.permit <= 1'b0;
				ctrl.wr     <= 1'b0;
				ctrl.rd     <= 1'b0;
			end else begin
				if (wr_ctrl && !busy)
					ctrl.space <= i_sfr.wdata[`NVM_BIT_SPACE];
				if (wr_ctrl) begin
					ctrl.abort  <= i_sfr.wdata[`NVM_BIT_ABORT];
					ctrl.permit <= i_sfr.wdata[`NVM_BIT_PERMIT];
				end
				if (start_write)
					ctrl.wr <= 1'b1;
				else if ((state == ST_PROGRAM) && timer_end)
					ctrl.wr <= 1'b0;
				if (start_read)
					ctrl.rd <= 1'b1;
				else if (load_data)
					ctrl.rd <= 1'b0;
			end
		end
	end

	// sequencer and timer; a soft reset abandons any access
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state        <= ST_IDLE;
			timer        <= `NVM_TIMER_ZERO;
			o_write_done <= 1'b0;
		end else if (i_clock_en) begin
			o_write_done <= 1'b0;
			if (soft_reset) begin
				state <= ST_IDLE;
				timer <= `NVM_TIMER_ZERO;
			end else begin
				case (state)
					ST_IDLE: begin
						if (start_write) begin
							state <= ST_ERASE;
							timer <= erase_len;
						end else if (start_read && i_sfr.wdata[`NVM_BIT_SPACE] && !ctrl.space)
							state <= ST_RD_LOAD;
						else if (start_read && ctrl.space)
							state <= ST_RD_WAIT;
						else if (start_read)
							state <= ST_RD_LOAD;
					end
					ST_RD_WAIT: state <= ST_RD_LOAD;
					ST_RD_LOAD: state <= ST_IDLE;
					ST_ERASE: begin
						if (timer_end) begin
							state <= ST_PROGRAM;
							timer <= program_len;
						end else
							timer <= timer - `NVM_TIMER_ONE;
					end
					ST_PROGRAM: begin
						if (timer_end) begin
							state        <= ST_IDLE;
							timer        <= `NVM_TIMER_ZERO;
							o_write_done <= 1'b1;
						end else
							timer <= timer - `NVM_TIMER_ONE;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// registered read data, valid the cycle after the read strobe
	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_sfr_rdata <= `NVM_BYTE_ZERO;
		else if (i_clock_en && i_sfr.rd)
			o_sfr_rdata <= read_mux;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst || !i_clock_en);

	property p_write_gate;
		$rose(ctrl.wr) |-> $past(ctrl.permit) && ($past(unlock) == UNLOCK_ARMED);
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write began without permit and key");

	property p_space_hold;
		busy && !soft_reset ##1 busy |-> $stable(ctrl.space);
	endproperty
	a_space_hold: assert property (p_space_hold) else $error("space select moved during access");

	property p_byte_read;
		(state == ST_RD_LOAD) && !ctrl.space && !soft_reset |=> (data_low == $past(ee_rdata)) && !ctrl.rd;
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read not loaded next cycle");

	property p_word_read;
		$rose(ctrl.rd) && ctrl.space && !soft_reset ##1 !soft_reset |-> ##1 !ctrl.rd;
	endproperty
	a_word_read: assert property (p_word_read) else $error("word read did not finish in two cycles");

	property p_stall;
		$rose(ctrl.wr) && ctrl.space |-> o_cpu_stall && o_irq_hold;
	endproperty
	a_stall: assert property (p_stall) else $error("program write did not stall the core");

	property p_done;
		o_write_done |-> !ctrl.wr && (state == ST_IDLE) && ($past(state) == ST_PROGRAM);
	endproperty
	a_done: assert property (p_done) else $error("completion without finished write");

	property p_abort;
		soft_reset && writing |=> ctrl.abort && !ctrl.wr && (state == ST_IDLE);
	endproperty
	a_abort: assert property (p_abort) else $error("interrupted write not flagged");

	property p_keep;
		soft_reset |=> $stable(addr_low) && $stable(addr_high) && $stable(data_low) && $stable(ctrl.space);
	endproperty
	a_keep: assert property (p_keep) else $error("soft reset changed kept registers");

	property p_high_zero;
		rd_hit(i_sfr, `NVM_OFS_DATA_HIGH) |=> (o_sfr_rdata[7:`NVM_DATA_HIGH_W] == 2'b00);
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("unused data bits read nonzero");
endmodule // nvm_self_access_ctrl

//--- nvm_core_fw.sv
// core firmware model that issues register accesses to the self-access controller
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_core_fw (
	// clock
	input  wire logic            i_clock,
	// register port
	output nvm_pkg::sfr_req_type o_sfr,
	input  wire logic [7:0]      i_rdata,
	// completion
	input  wire logic            i_write_done
);
	import nvm_pkg::*;
	logic write_complete_flag = 1'b0;
	initial o_sfr = '0;
	always @(posedge i_clock) begin
		if (i_write_done) write_complete_flag <= 1'b1;
	end
	// strobe held until the taking edge; a released bus shows inverted bits, not the last value
	task automatic sfr_wr(input logic [8:0] addr, input logic [7:0] data);
		@(posedge i_clock);
		o_sfr <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
		@(posedge i_clock);
		o_sfr <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
	endtask
	task automatic sfr_rd(input logic [8:0] addr, output logic [7:0] data);
		@(posedge i_clock);
		o_sfr <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h5A};
		@(posedge i_clock);
		o_sfr <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
		#1 data = i_rdata;
	endtask
	// key pair and trigger back to back; any other register write between would void the key
	task automatic start_write(input logic [7:0] ctrl);
		write_complete_flag <= 1'b0;
		sfr_wr(`NVM_OFS_UNLOCK, `NVM_UNLOCK_FIRST);
		sfr_wr(`NVM_OFS_UNLOCK, `NVM_UNLOCK_SECOND);
		sfr_wr(`NVM_OFS_CONTROL, ctrl);
	endtask
endmodule // nvm_core_fw

//--- nvm_self_access_ctrl_tb_top.sv
// self-checking bench of the self-access controller against a behavioural memory model
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_self_access_ctrl_tb_top;
	import nvm_pkg::*;
	localparam int ERASE_N = 8;
	localparam int PROG_N  = 8;
	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_clock_en = 1'b1;
	logic        i_external_reset_pin = 1'b0;
	logic        i_watchdog_timeout = 1'b0;
	wire  sfr_req_type i_sfr;
	logic [7:0]  o_sfr_rdata;
	logic        o_cpu_stall;
	logic        o_irq_hold;
	logic        o_write_done;
	int          n_mismatch = 0;
	int          compares = 0;
	bit   [7:0]  ee_m [0:63];
	bit   [13:0] fl_m [0:2047];
	always #10 i_clock = ~i_clock;

	nvm_self_access_ctrl #(.ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N)) nvm_self_access_ctrl_inst (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clock_en(i_clock_en),
		.i_sfr(i_sfr),
		.o_sfr_rdata(o_sfr_rdata),
		.i_external_reset_pin(i_external_reset_pin),
		.i_watchdog_timeout(i_watchdog_timeout),
		.o_cpu_stall(o_cpu_stall),
		.o_irq_hold(o_irq_hold),
		.o_write_done(o_write_done)
	);
	nvm_core_fw nvm_core_fw_inst (
		.i_clock(i_clock),
		.o_sfr(i_sfr),
		.i_rdata(o_sfr_rdata),
		.i_write_done(o_write_done)
	);

	task automatic final_report();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [8:0] addr, input logic [7:0] data);
		nvm_core_fw_inst.sfr_wr(addr, data);
	endtask
	task automatic rd_chk(input string name, input logic [8:0] addr, input logic [15:0] exp);
		logic [7:0] d;
		nvm_core_fw_inst.sfr_rd(addr, d);
		chk(name, exp, {8'h00, d});
	endtask
	// counts stalled cycles until the completion pulse; a lost pulse ends the run
	task automatic wait_done(input logic [15:0] stall_exp);
		int n;
		int stall_n;
		int hold_n;
		stall_n = 0;
		hold_n = 0;
		for (n = 0; n < 100; n++) begin
			#1;
			if (o_cpu_stall === 1'b1) stall_n++;
			if (o_irq_hold === 1'b1) hold_n++;
			if (o_write_done === 1'b1) break;
			@(posedge i_clock);
		end
		if (n == 100) begin
			n_mismatch++;
			$display("ERROR write_done expected 1 seen 0");
			final_report();
		end else begin
			chk("stall_cycles", stall_exp, stall_n[15:0]);
			chk("irq_hold_cycles", stall_exp, hold_n[15:0]);
		end
	endtask

	initial begin
		logic [7:0]  a;
		logic [7:0]  d;
		logic [7:0]  h;
		logic [10:0] wa;
		logic [13:0] wd;
		int          k;
		int          n;
		void'($urandom(32'h8b27));
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		wr(`NVM_OFS_CONTROL, 8'h00);
		rd_chk("control", `NVM_OFS_CONTROL, 16'h0000);
		wr(`NVM_OFS_UNLOCK, 8'h55);
		rd_chk("unlock", `NVM_OFS_UNLOCK, 16'h0000);
		wr(`NVM_OFS_ADDR_HIGH, 8'hFF);
		rd_chk("addr_high", `NVM_OFS_ADDR_HIGH, 16'h00FF);
		// a write taken while the enable is low must not land
		@(posedge i_clock);
		i_clock_en <= 1'b0;
		wr(`NVM_OFS_ADDR_HIGH, 8'h00);
		i_clock_en <= 1'b1;
		rd_chk("addr_high_frozen", `NVM_OFS_ADDR_HIGH, 16'h00FF);
		for (k = 0; k < 4; k++) begin
			a = 8'($urandom_range(63));
			d = 8'($urandom);
			h = 8'($urandom);
			ee_m[a] = d;
			wr(`NVM_OFS_ADDR_LOW, a);
			wr(`NVM_OFS_ADDR_HIGH, h);
			wr(`NVM_OFS_DATA_LOW, d);
			wr(`NVM_OFS_DATA_HIGH, h);
			rd_chk("data_high", `NVM_OFS_DATA_HIGH, {10'h000, h[5:0]});
			wr(`NVM_OFS_CONTROL, 8'h04);
			nvm_core_fw_inst.start_write(8'h06);
			wr(`NVM_OFS_CONTROL, 8'h84);
			rd_chk("control_busy", `NVM_OFS_CONTROL, 16'h0006);
			wait_done(16'h0000);
			rd_chk("control_done", `NVM_OFS_CONTROL, 16'h0004);
			chk("complete_flag", 16'h0001, {15'h0000, nvm_core_fw_inst.write_complete_flag});
			wr(`NVM_OFS_DATA_LOW, ~d);
			wr(`NVM_OFS_CONTROL, 8'h05);
			@(posedge i_clock);
			rd_chk("data_low", `NVM_OFS_DATA_LOW, {8'h00, ee_m[a]});
			rd_chk("control_rd", `NVM_OFS_CONTROL, 16'h0004);
		end
		// three ways to get the trigger refused: no key, permit set together, key reversed
		for (k = 0; k < 3; k++) begin
			wr(`NVM_OFS_CONTROL, (k == 1) ? 8'h00 : 8'h04);
			if (k == 2) begin
				wr(`NVM_OFS_UNLOCK, 8'hAA);
				wr(`NVM_OFS_UNLOCK, 8'h55);
			end
			if (k == 1) begin
				nvm_core_fw_inst.start_write(8'h06);
			end else begin
				wr(`NVM_OFS_CONTROL, 8'h06);
			end
			n = 0;
			repeat (30) begin
				@(posedge i_clock);
				#1;
				if (o_write_done !== 1'b0) n++;
			end
			chk("refused_done", 16'h0000, n[15:0]);
			if (k == 1) chk("refused_flag", 16'h0000, {15'h0000, nvm_core_fw_inst.write_complete_flag});
			rd_chk("control_refused", `NVM_OFS_CONTROL, 16'h0004);
		end
		for (k = 0; k < 2; k++) begin
			wa = 11'($urandom);
			wd = 14'($urandom);
			fl_m[wa] = wd;
			wr(`NVM_OFS_ADDR_LOW, wa[7:0]);
			wr(`NVM_OFS_ADDR_HIGH, {5'b00000, wa[10:8]});
			wr(`NVM_OFS_DATA_LOW, wd[7:0]);
			wr(`NVM_OFS_DATA_HIGH, {2'b00, wd[13:8]});
			wr(`NVM_OFS_CONTROL, 8'h84);
			nvm_core_fw_inst.start_write(8'h86);
			wait_done(16'(ERASE_N + PROG_N));
			wr(`NVM_OFS_DATA_LOW, 8'h00);
			chk("word_flag", 16'h0001, {15'h0000, nvm_core_fw_inst.write_complete_flag});
			wr(`NVM_OFS_DATA_HIGH, 8'h00);
			wr(`NVM_OFS_CONTROL, 8'h85);
			repeat (2) @(posedge i_clock);
			rd_chk("word_low", `NVM_OFS_DATA_LOW, {8'h00, fl_m[wa][7:0]});
			rd_chk("word_high", `NVM_OFS_DATA_HIGH, {10'h000, fl_m[wa][13:8]});
		end
		// one abort by the reset pin, one by the watchdog, both in mid-write
		for (k = 0; k < 2; k++) begin
			wr(`NVM_OFS_ADDR_LOW, 8'h15);
			wr(`NVM_OFS_DATA_LOW, 8'h3C);
			wr(`NVM_OFS_CONTROL, 8'h84);
			nvm_core_fw_inst.start_write(8'h86);
			if (k == 0) begin
				i_external_reset_pin <= 1'b1;
			end else begin
				i_watchdog_timeout <= 1'b1;
			end
			repeat (6) @(posedge i_clock);
			i_external_reset_pin <= 1'b0;
			i_watchdog_timeout <= 1'b0;
			repeat (6) @(posedge i_clock);
			rd_chk("control_abort", `NVM_OFS_CONTROL, 16'h0088);
			rd_chk("addr_low_kept", `NVM_OFS_ADDR_LOW, 16'h0015);
			rd_chk("data_low_kept", `NVM_OFS_DATA_LOW, 16'h003C);
			wr(`NVM_OFS_CONTROL, 8'h00);
		end
		final_report();
	end
endmodule // nvm_self_access_ctrl_tb_top
